// *** nv_pkg.sv ***
// Constants, field positions and state type for the nonvolatile access controller
`default_nettype none
package nv_pkg;
	// ----------------------------------------------------------------
	// Register offsets on the special function register port
	// ----------------------------------------------------------------
	localparam logic [8:0] ADDR_DATA_LOW = 9'h10C;
	localparam logic [8:0] ADDR_ADDRESS_LOW = 9'h10D;
	localparam logic [8:0] ADDR_DATA_HIGH = 9'h10E;
	localparam logic [8:0] ADDR_ADDRESS_HIGH = 9'h10F;
	localparam logic [8:0] ADDR_CONTROL = 9'h18C;
	localparam logic [8:0] ADDR_UNLOCK = 9'h18D;
	localparam logic [8:0] ADDR_FLAGS_TWO = 9'h00D;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_READ_BIT = 0;
	localparam int CTRL_WRITE_BIT = 1;
	localparam int CTRL_PERMIT_BIT = 2;
	localparam int CTRL_ABORT_BIT = 3;
	localparam int CTRL_SPACE_BIT = 7;
	localparam int FLAGS_DONE_BIT = 4;
	localparam int DATA_HIGH_W = 6;
	localparam int ADDR_HIGH_W = 4;

	// ----------------------------------------------------------------
	// Reset values and fixed codes
	// ----------------------------------------------------------------
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] UNLOCK_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
	localparam int EEPROM_DEPTH = 256;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int ERASE_TIME_NS = 2000000;
	localparam int PROGRAM_TIME_NS = 2000000;
	localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DATA_READ,
		ST_FLASH_WAIT,
		ST_FLASH_CAPTURE,
		ST_ERASE,
		ST_PROGRAM
	} state_t;
endpackage
`default_nettype wire

// *** nv_array_if.sv ***
// Interface between the sequencer and the byte storage array
`timescale 1ns/10ps
`default_nettype none
interface nv_array_if #(
	parameter int AW = 8
);
	logic wr;
	logic [AW-1:0] waddr;
	logic [7:0] wdata;
	logic [AW-1:0] raddr;
	logic [7:0] rdata;

	modport ctrl (output wr, output waddr, output wdata, output raddr, input rdata);
	modport mem (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// *** nv_byte_array.sv ***
// Flip-flop byte storage for the data EEPROM
`timescale 1ns/10ps
`default_nettype none
module nv_byte_array #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Storage port
	nv_array_if.mem arr
);
	logic [7:0] mem_ff [DEPTH];

	// Contents survive reset, like the real cells
	always_ff @(posedge clk) begin
		if (arr.wr) begin
			mem_ff[arr.waddr] <= arr.wdata;
		end
	end

	// Asynchronous read, sampled by the sequencer
	assign arr.rdata = mem_ff[arr.raddr];

	logic unused_rst;
	assign unused_rst = rst;
endmodule
`default_nettype wire

// *** nv_write_timer.sv ***
// Down counter that times the erase and program phases
`timescale 1ns/10ps
`default_nettype none
module nv_write_timer #(
	parameter int CW = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic [CW-1:0] load,
	// Status
	output logic busy,
	output logic done
);
	logic [CW-1:0] count_ff;

	// Load on start, count down, signal done on the last cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= '0;
		end else if (start) begin
			count_ff <= load;
		end else if (count_ff != '0) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	assign busy = (count_ff != '0);
	assign done = (count_ff == {{(CW-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// *** nv_access_ctrl.sv ***
// Register-driven access controller for data EEPROM and program flash reads
`timescale 1ns/10ps
`default_nettype none
module nv_access_ctrl #(
	parameter int DEPTH = nv_pkg::EEPROM_DEPTH,
	parameter int ERASE_CYCLES = nv_pkg::ERASE_CYCLES,
	parameter int PROGRAM_CYCLES = nv_pkg::PROGRAM_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic warm_reset,
	// Special function register port
	input wire logic [8:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Program flash read port
	output logic flash_rd,
	output logic [11:0] flash_addr,
	input wire logic [13:0] flash_rdata,
	// External programmer port
	input wire logic code_protect,
	input wire logic prog_rd,
	input wire logic prog_wr,
	input wire logic [7:0] prog_addr,
	input wire logic [7:0] prog_wdata,
	output logic [7:0] prog_rdata,
	output logic prog_ack,
	output logic prog_denied,
	// Status
	output logic write_done
);
	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] data_low_ff;
	logic [nv_pkg::DATA_HIGH_W-1:0] data_high_ff;
	logic [7:0] address_low_ff;
	logic [nv_pkg::ADDR_HIGH_W-1:0] address_high_ff;
	logic space_ff;
	logic permit_ff;
	logic abort_ff;
	logic read_trig_ff;
	logic write_trig_ff;
	logic done_flag_ff;
	logic [1:0] unlock_ff;
	logic [AW-1:0] op_addr_ff;
	logic [7:0] op_data_ff;
	nv_pkg::state_t state_ff;
	logic [7:0] sfr_rdata_ff;
	logic flash_rd_ff;
	logic [11:0] flash_addr_ff;
	logic [7:0] prog_rdata_ff;
	logic prog_ack_ff;
	logic prog_denied_ff;

	logic t_start;
	logic [31:0] t_load;
	logic t_done;
	logic start_write;
	logic start_read;
	logic prog_ok;

	nv_array_if #(.AW(AW)) arr ();

	// Write strobe decode for one register offset
	function automatic logic hit(input logic wr, input logic [8:0] a, input logic [8:0] t);
		hit = wr && (a == t);
	endfunction

	// Array index from a byte address; upper bit dropped on the small variant
	function automatic logic [AW-1:0] idx(input logic [7:0] a);
		idx = a[AW-1:0];
	endfunction

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	nv_byte_array #(.DEPTH(DEPTH), .AW(AW)) u_array (
		.clk(clk),
		.rst(rst),
		.arr(arr.mem)
	);

	nv_write_timer #(.CW(32)) u_timer (
		.clk(clk),
		.rst(rst),
		.start(t_start),
		.load(t_load),
		.busy(),
		.done(t_done)
	);

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	// Write needs: idle, permit, data space, armed unlock, trigger bit set
	assign start_write = hit(sfr_wr, sfr_addr, nv_pkg::ADDR_CONTROL)
		&& sfr_wdata[nv_pkg::CTRL_WRITE_BIT] && (state_ff == nv_pkg::ST_IDLE)
		&& permit_ff && !sfr_wdata[nv_pkg::CTRL_SPACE_BIT]
		&& (unlock_ff == 2'd2);
	// A write request wins over a read set in the same store
	assign start_read = hit(sfr_wr, sfr_addr, nv_pkg::ADDR_CONTROL)
		&& sfr_wdata[nv_pkg::CTRL_READ_BIT] && (state_ff == nv_pkg::ST_IDLE)
		&& !start_write;
	// Programmer only reaches the array when unprotected and idle
	assign prog_ok = (prog_rd || prog_wr) && !code_protect
		&& (state_ff == nv_pkg::ST_IDLE);

	// Timer kicks: erase at start, program after erase
	always_comb begin
		t_start = 1'b0;
		t_load = 32'h0000_0000;
		if (start_write) begin
			t_start = 1'b1;
			t_load = 32'(ERASE_CYCLES);
		end else if (state_ff == nv_pkg::ST_ERASE && t_done) begin
			t_start = 1'b1;
			t_load = 32'(PROGRAM_CYCLES);
		end
	end

	// Array port: erase writes all ones, program writes the byte
	always_comb begin
		arr.wr = 1'b0;
		arr.waddr = op_addr_ff;
		arr.wdata = op_data_ff;
		arr.raddr = op_addr_ff;
		if (state_ff == nv_pkg::ST_ERASE && t_done) begin
			arr.wr = 1'b1;
			arr.wdata = nv_pkg::ERASED_BYTE;
		end else if (state_ff == nv_pkg::ST_PROGRAM && t_done) begin
			arr.wr = 1'b1;
		end else if (prog_ok) begin
			arr.wr = prog_wr;
			arr.waddr = idx(prog_addr);
			arr.wdata = prog_wdata;
			arr.raddr = idx(prog_addr);
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= nv_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				nv_pkg::ST_IDLE: begin
					if (start_write) begin
						state_ff <= nv_pkg::ST_ERASE;
					end else if (start_read && sfr_wdata[nv_pkg::CTRL_SPACE_BIT]) begin
						state_ff <= nv_pkg::ST_FLASH_WAIT;
					end else if (start_read) begin
						state_ff <= nv_pkg::ST_DATA_READ;
					end
				end
				nv_pkg::ST_DATA_READ: state_ff <= nv_pkg::ST_IDLE;
				nv_pkg::ST_FLASH_WAIT: state_ff <= nv_pkg::ST_FLASH_CAPTURE;
				nv_pkg::ST_FLASH_CAPTURE: state_ff <= nv_pkg::ST_IDLE;
				nv_pkg::ST_ERASE: begin
					if (t_done) begin
						state_ff <= nv_pkg::ST_PROGRAM;
					end
				end
				nv_pkg::ST_PROGRAM: begin
					if (t_done) begin
						state_ff <= nv_pkg::ST_IDLE;
					end
				end
				default: state_ff <= nv_pkg::ST_IDLE;
			endcase
		end
	end

	// Operation address and byte latched at write or read start
	always_ff @(posedge clk) begin
		if (rst) begin
			op_addr_ff <= '0;
			op_data_ff <= nv_pkg::BYTE_RESET;
		end else if (start_write || start_read) begin
			op_addr_ff <= idx(address_low_ff);
			op_data_ff <= data_low_ff;
		end
	end

	// Flash read strobe and word address
	always_ff @(posedge clk) begin
		if (rst) begin
			flash_rd_ff <= 1'b0;
			flash_addr_ff <= 12'h000;
		end else begin
			flash_rd_ff <= start_read && sfr_wdata[nv_pkg::CTRL_SPACE_BIT];
			if (start_read) begin
				flash_addr_ff <= {address_high_ff, address_low_ff};
			end
		end
	end

	// ----------------------------------------------------------------
	// Data and address registers
	// ----------------------------------------------------------------
	// Hardware read results overwrite software stores
	always_ff @(posedge clk) begin
		if (rst) begin
			data_low_ff <= nv_pkg::BYTE_RESET;
			data_high_ff <= '0;
		end else if (state_ff == nv_pkg::ST_DATA_READ) begin
			data_low_ff <= arr.rdata;
		end else if (state_ff == nv_pkg::ST_FLASH_CAPTURE) begin
			data_low_ff <= flash_rdata[7:0];
			data_high_ff <= flash_rdata[13:8];
		end else begin
			if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_DATA_LOW)) begin
				data_low_ff <= sfr_wdata;
			end
			if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_DATA_HIGH)) begin
				data_high_ff <= sfr_wdata[nv_pkg::DATA_HIGH_W-1:0];
			end
		end
	end

	// Address bytes, plain software storage
	always_ff @(posedge clk) begin
		if (rst) begin
			address_low_ff <= nv_pkg::BYTE_RESET;
			address_high_ff <= '0;
		end else begin
			if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_ADDRESS_LOW)) begin
				address_low_ff <= sfr_wdata;
			end
			if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_ADDRESS_HIGH)) begin
				address_high_ff <= sfr_wdata[nv_pkg::ADDR_HIGH_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Control bits
	// ----------------------------------------------------------------
	// Space select and permit are plain; permit clears on every reset
	always_ff @(posedge clk) begin
		if (rst) begin
			space_ff <= 1'b0;
			permit_ff <= 1'b0;
		end else if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_CONTROL)) begin
			space_ff <= sfr_wdata[nv_pkg::CTRL_SPACE_BIT];
			permit_ff <= sfr_wdata[nv_pkg::CTRL_PERMIT_BIT];
		end
	end

	// Triggers: zero stores ignored, so a write cannot be cut short
	always_ff @(posedge clk) begin
		if (rst) begin
			read_trig_ff <= 1'b0;
			write_trig_ff <= 1'b0;
		end else begin
			if (start_read) begin
				read_trig_ff <= 1'b1;
			end else if (state_ff == nv_pkg::ST_DATA_READ || state_ff == nv_pkg::ST_FLASH_CAPTURE) begin
				read_trig_ff <= 1'b0;
			end
			if (start_write) begin
				write_trig_ff <= 1'b1;
			end else if (state_ff == nv_pkg::ST_PROGRAM && t_done) begin
				write_trig_ff <= 1'b0;
			end
		end
	end

	// Abort flag survives warm resets; only a cold reset or software clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			if (!warm_reset) begin
				abort_ff <= 1'b0;
			end else if (state_ff == nv_pkg::ST_ERASE || state_ff == nv_pkg::ST_PROGRAM) begin
				abort_ff <= 1'b1;
			end
		end else if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_CONTROL)) begin
			abort_ff <= sfr_wdata[nv_pkg::CTRL_ABORT_BIT];
		end
	end

	// Unlock pair tracker; any other store disarms it
	always_ff @(posedge clk) begin
		if (rst) begin
			unlock_ff <= 2'd0;
		end else if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_UNLOCK)) begin
			if (sfr_wdata == nv_pkg::UNLOCK_FIRST) begin
				unlock_ff <= 2'd1;
			end else if (sfr_wdata == nv_pkg::UNLOCK_SECOND && unlock_ff == 2'd1) begin
				unlock_ff <= 2'd2;
			end else begin
				unlock_ff <= 2'd0;
			end
		end else if (sfr_wr) begin
			unlock_ff <= 2'd0;
		end
	end

	// Done flag: completion set beats a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			done_flag_ff <= 1'b0;
		end else if (state_ff == nv_pkg::ST_PROGRAM && t_done) begin
			done_flag_ff <= 1'b1;
		end else if (hit(sfr_wr, sfr_addr, nv_pkg::ADDR_FLAGS_TWO)) begin
			done_flag_ff <= sfr_wdata[nv_pkg::FLAGS_DONE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	// Registered read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			sfr_rdata_ff <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				nv_pkg::ADDR_DATA_LOW: sfr_rdata_ff <= data_low_ff;
				nv_pkg::ADDR_DATA_HIGH: sfr_rdata_ff <= {2'b00, data_high_ff};
				nv_pkg::ADDR_ADDRESS_LOW: sfr_rdata_ff <= address_low_ff;
				nv_pkg::ADDR_ADDRESS_HIGH: sfr_rdata_ff <= {4'h0, address_high_ff};
				nv_pkg::ADDR_CONTROL: begin
					sfr_rdata_ff <= {space_ff, 3'b000, abort_ff, permit_ff,
						write_trig_ff, read_trig_ff};
				end
				nv_pkg::ADDR_FLAGS_TWO: sfr_rdata_ff <= {3'b000, done_flag_ff, 4'h0};
				nv_pkg::ADDR_UNLOCK: sfr_rdata_ff <= 8'h00;
				default: sfr_rdata_ff <= 8'h00;
			endcase
		end
	end

	// Programmer answers: ack with data, or a denial pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			prog_rdata_ff <= 8'h00;
			prog_ack_ff <= 1'b0;
			prog_denied_ff <= 1'b0;
		end else begin
			prog_ack_ff <= prog_ok;
			prog_denied_ff <= (prog_rd || prog_wr) && !prog_ok;
			if (prog_ok && prog_rd) begin
				prog_rdata_ff <= arr.rdata;
			end
		end
	end

	// Outputs straight from flip-flops
	assign sfr_rdata = sfr_rdata_ff;
	assign flash_rd = flash_rd_ff;
	assign flash_addr = flash_addr_ff;
	assign prog_rdata = prog_rdata_ff;
	assign prog_ack = prog_ack_ff;
	assign prog_denied = prog_denied_ff;
	assign write_done = done_flag_ff;
endmodule
`default_nettype wire

// *** nv_access_ctrl_assertions.sv ***
// Concurrent port checks for the nonvolatile access controller
`timescale 1ns/10ps
`default_nettype none
module nv_access_ctrl_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [8:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// Flash, programmer and status
	input wire logic flash_rd,
	input wire logic [11:0] flash_addr,
	input wire logic code_protect,
	input wire logic prog_rd,
	input wire logic prog_wr,
	input wire logic prog_ack,
	input wire logic prog_denied,
	input wire logic write_done
);
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Stores to the flags register may legally move the done mirror
	logic flag_store;
	assign flag_store = sfr_wr && sfr_addr == nv_pkg::ADDR_FLAGS_TWO;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_unlock_reads_zero: assert property (
		sfr_rd && sfr_addr == nv_pkg::ADDR_UNLOCK |=> sfr_rdata == 8'h00)
		else $error("unlock port read back nonzero");
	chk_rdata_holds: assert property (
		!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	chk_flash_one_word: assert property (
		flash_rd |=> !flash_rd && $stable(flash_addr))
		else $error("flash read longer than one word");
	chk_flash_cause: assert property (
		$rose(flash_rd) |-> $past(sfr_wr && sfr_addr == nv_pkg::ADDR_CONTROL
			&& sfr_wdata[nv_pkg::CTRL_READ_BIT] && sfr_wdata[nv_pkg::CTRL_SPACE_BIT]))
		else $error("flash read without program space read request");
	chk_prog_answer: assert property (
		prog_rd || prog_wr |=> prog_ack ^ prog_denied)
		else $error("programmer request not answered once");
	chk_prog_protect: assert property (
		(prog_rd || prog_wr) && code_protect |=> prog_denied)
		else $error("protected programmer request not denied");
	chk_ack_needs_open: assert property (
		prog_ack |-> $past(!code_protect && (prog_rd || prog_wr)))
		else $error("programmer ack without open request");
	chk_done_sticky: assert property (
		write_done && !flag_store && !$past(flag_store) |=> write_done)
		else $error("write done dropped without software clear");
endmodule

bind nv_access_ctrl nv_access_ctrl_assertions chk_i (.clk(clk), .rst(rst),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .flash_rd(flash_rd), .flash_addr(flash_addr),
	.code_protect(code_protect), .prog_rd(prog_rd), .prog_wr(prog_wr),
	.prog_ack(prog_ack), .prog_denied(prog_denied), .write_done(write_done));
`default_nettype wire

// *** eeprom_flash_access_ctrl_tb_top.sv ***
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_flash_access_ctrl_tb_top;
	// Short timed phases keep the run brief
	localparam int ERASE_N = 8;
	localparam int PROG_N = 8;
	typedef struct {string name; logic [15:0] exp; logic [15:0] mask;} note_t;
	logic clk = 1'b0;
	logic rst, warm_reset, sfr_wr, sfr_rd, code_protect, prog_rd, prog_wr;
	logic [8:0] sfr_addr;
	logic [7:0] sfr_wdata, sfr_rdata, prog_addr, prog_wdata, prog_rdata, d, e;
	logic [11:0] flash_addr, fa;
	logic [13:0] flash_rdata = 14'h0000;
	logic flash_rd, prog_ack, prog_denied, write_done, rd_pend;
	note_t sq[$], pq[$], n;
	integer errors = 0, checked = 0, cyc = 0, t0;

	nv_access_ctrl #(.DEPTH(256), .ERASE_CYCLES(ERASE_N), .PROGRAM_CYCLES(PROG_N)) uut (
		.clk(clk), .rst(rst), .warm_reset(warm_reset), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
		.code_protect(code_protect), .prog_rd(prog_rd), .prog_wr(prog_wr),
		.prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
		.prog_ack(prog_ack), .prog_denied(prog_denied), .write_done(write_done));

	// ----------------------------------------------------------------
	// Clock, flash model and result watcher
	// ----------------------------------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end

	// Flash word is a fixed scramble of its address, so every address differs
	function automatic logic [13:0] fword(input logic [11:0] a);
		return {a, 2'b10} ^ 14'h1A5C;
	endfunction

	always @(negedge clk) flash_rdata <= fword(flash_addr);
	always @(posedge clk) rd_pend <= sfr_rd;
	always @(posedge clk) cyc <= cyc + 1;

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Results are sampled half a cycle after they land, oldest note first
	always @(negedge clk) begin
		if (rd_pend === 1'b1 && sq.size() > 0) begin
			n = sq.pop_front();
			chk(n.name, {8'h00, sfr_rdata} & n.mask, n.exp);
		end
		if ((prog_ack | prog_denied) === 1'b1 && pq.size() > 0) begin
			n = pq.pop_front();
			chk(n.name, {6'h00, prog_denied, prog_ack, prog_rdata} & n.mask, n.exp);
		end
		if (flash_rd === 1'b1) begin
			chk("flash address", {4'h0, flash_addr}, {4'h0, fa});
		end
	end

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task automatic bus(input logic w, input logic r, input logic [8:0] a, input logic [7:0] v);
		sfr_wr = w;
		sfr_rd = r;
		sfr_addr = a;
		sfr_wdata = v;
		@(negedge clk);
	endtask

	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		bus(1'b1, 1'b0, a, v);
	endtask

	task automatic rd(input string nm, input logic [8:0] a, input logic [7:0] x,
		input logic [7:0] m);
		sq.push_back('{nm, {8'h00, x}, {8'h00, m}});
		bus(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic idle(input int k);
		repeat (k) bus(1'b0, 1'b0, sfr_addr, sfr_wdata);
	endtask

	// Programmer request: strobe one cycle, then one quiet cycle
	task automatic prog(input logic w, input logic [7:0] a, input logic [7:0] v,
		input logic [15:0] x, input logic [15:0] m);
		pq.push_back('{"programmer", x, m});
		prog_rd = ~w;
		prog_wr = w;
		prog_addr = a;
		prog_wdata = v;
		@(negedge clk);
		prog_rd = 1'b0;
		prog_wr = 1'b0;
		@(negedge clk);
	endtask

	task automatic arm_and_write(input logic [7:0] c);
		wr(nv_pkg::ADDR_UNLOCK, nv_pkg::UNLOCK_FIRST);
		wr(nv_pkg::ADDR_UNLOCK, nv_pkg::UNLOCK_SECOND);
		wr(nv_pkg::ADDR_CONTROL, c);
		t0 = cyc;
		idle(1);
	endtask

	task automatic do_reset(input logic w, input int k);
		rst = 1'b1;
		warm_reset = w;
		repeat (k) @(negedge clk);
		rst = 1'b0;
		warm_reset = 1'b0;
		// First request only after one edge has seen reset low
		@(negedge clk);
	endtask

	task automatic test_done();
		// A note never answered is a missing result
		errors += sq.size() + pq.size();
		if (errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Watchdog far beyond the under two hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		test_done();
	end

	// Main sequence
	initial begin
		void'($urandom(32'hf3ca));
		{sfr_wr, sfr_rd, code_protect, prog_rd, prog_wr} = 5'h00;
		{sfr_addr, sfr_wdata, prog_addr, prog_wdata, fa} = '0;
		warm_reset = 1'b0;
		do_reset(1'b0, 10);
		rd("control", nv_pkg::ADDR_CONTROL, 8'h00, 8'hFF);
		rd("unlock", nv_pkg::ADDR_UNLOCK, 8'h00, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			d = $urandom;
			wr(nv_pkg::ADDR_DATA_LOW, d);
			wr(nv_pkg::ADDR_DATA_HIGH, d);
			wr(nv_pkg::ADDR_ADDRESS_HIGH, d);
			rd("data low", nv_pkg::ADDR_DATA_LOW, d, 8'hFF);
			rd("data high", nv_pkg::ADDR_DATA_HIGH, d & 8'h3F, 8'hFF);
			rd("addr high", nv_pkg::ADDR_ADDRESS_HIGH, d & 8'h0F, 8'hFF);
		end
		// Write requests that must be refused
		wr(nv_pkg::ADDR_CONTROL, 8'h04);
		wr(nv_pkg::ADDR_CONTROL, 8'h06);
		rd("control", nv_pkg::ADDR_CONTROL, 8'h04, 8'hFF);
		wr(nv_pkg::ADDR_CONTROL, 8'h00);
		arm_and_write(8'h02);
		rd("control", nv_pkg::ADDR_CONTROL, 8'h00, 8'hFF);
		wr(nv_pkg::ADDR_CONTROL, 8'h04);
		arm_and_write(8'h86);
		rd("control", nv_pkg::ADDR_CONTROL, 8'h84, 8'hFF);
		// Timed write to the top location
		d = $urandom;
		wr(nv_pkg::ADDR_CONTROL, 8'h04);
		wr(nv_pkg::ADDR_ADDRESS_LOW, 8'hFF);
		wr(nv_pkg::ADDR_DATA_LOW, d);
		arm_and_write(8'h06);
		rd("control", nv_pkg::ADDR_CONTROL, 8'h06, 8'hFF);
		wr(nv_pkg::ADDR_CONTROL, 8'h04);
		rd("control", nv_pkg::ADDR_CONTROL, 8'h06, 8'hFF);
		idle(1);
		prog(1'b0, 8'hFF, 8'h00, 16'h0200, 16'h0300);
		for (int k = 0; k < 200 && write_done !== 1'b1; k++) @(negedge clk);
		t0 = cyc - t0;
		chk("write time", 16'(t0), 16'(ERASE_N + PROG_N));
		rd("control", nv_pkg::ADDR_CONTROL, 8'h04, 8'hFF);
		rd("flags", nv_pkg::ADDR_FLAGS_TWO, 8'h10, 8'h10);
		wr(nv_pkg::ADDR_DATA_LOW, 8'h00);
		wr(nv_pkg::ADDR_CONTROL, 8'h05);
		idle(2);
		rd("eeprom byte", nv_pkg::ADDR_DATA_LOW, d, 8'hFF);
		idle(4);
		chk("done level", {15'h0000, write_done}, 16'h0001);
		wr(nv_pkg::ADDR_FLAGS_TWO, 8'h00);
		idle(3);
		chk("done level", {15'h0000, write_done}, 16'h0000);
		// Programmer access, protected and open
		code_protect = 1'b1;
		prog(1'b0, 8'hFF, 8'h00, 16'h0200, 16'h0300);
		code_protect = 1'b0;
		prog(1'b0, 8'hFF, 8'h00, {8'h01, d}, 16'h03FF);
		e = $urandom;
		prog(1'b1, 8'h10, e, 16'h0100, 16'h0300);
		wr(nv_pkg::ADDR_ADDRESS_LOW, 8'h10);
		wr(nv_pkg::ADDR_CONTROL, 8'h05);
		idle(2);
		rd("eeprom byte", nv_pkg::ADDR_DATA_LOW, e, 8'hFF);
		// Program flash word reads
		for (int i = 0; i < 3; i++) begin
			fa = 12'($urandom);
			wr(nv_pkg::ADDR_ADDRESS_HIGH, {4'h0, fa[11:8]});
			wr(nv_pkg::ADDR_ADDRESS_LOW, fa[7:0]);
			wr(nv_pkg::ADDR_CONTROL, 8'h81);
			idle(3);
			rd("flash low", nv_pkg::ADDR_DATA_LOW, 8'(fword(fa)), 8'hFF);
			rd("flash high", nv_pkg::ADDR_DATA_HIGH, 8'(fword(fa) >> 8), 8'hFF);
		end
		// Warm reset in mid-write, then a cold reset
		wr(nv_pkg::ADDR_CONTROL, 8'h04);
		arm_and_write(8'h06);
		idle(3);
		do_reset(1'b1, 2);
		rd("abort flag", nv_pkg::ADDR_CONTROL, 8'h08, 8'h08);
		idle(1);
		do_reset(1'b0, 2);
		rd("abort and permit", nv_pkg::ADDR_CONTROL, 8'h00, 8'h0C);
		idle(3);
		test_done();
	end
endmodule
`default_nettype wire
